//--- hw/mgbm_pkg.sv
// constants and types for the multicast group binding maintenance block
// assumes a 10 MHz clock; offsets are byte addresses on a 32-bit apb bus
package mgbm_pkg;
   // ==========================================================
   // bus and sizes
   localparam int unsigned MGBM_AW = 8;
   localparam int unsigned MGBM_NRX = 8;
   localparam int unsigned MGBM_NBAT = 32;
   localparam logic [31:0] MGBM_ZERO_WORD = 32'h0000_0000;
   // ==========================================================
   // register offsets
   localparam logic [7:0] MGBM_CTRL_OFS = 8'h00;
   localparam logic [7:0] MGBM_STAT_OFS = 8'h04;
   localparam logic [7:0] MGBM_MEMB_OFS = 8'h08;
   localparam logic [7:0] MGBM_SLOT_OFS = 8'h0C;
   localparam logic [7:0] MGBM_BATW_OFS = 8'h10;
   localparam logic [7:0] MGBM_BATA_OFS = 8'h14;
   localparam logic [7:0] MGBM_CNF_OFS = 8'h18;
   localparam logic [7:0] MGBM_RMV_OFS = 8'h1C;
   localparam logic [7:0] MGBM_BUF_OFS = 8'h20;
   localparam logic [7:0] MGBM_GRPI_OFS = 8'h24;
   // ==========================================================
   // ctrl register fields (write one to send, term or split; flow, did and retry are stored values)
   localparam int unsigned MGBM_CTRL_SEND_BIT = 0;
   localparam int unsigned MGBM_CTRL_TERM_BIT = 1;
   localparam int unsigned MGBM_CTRL_SPLIT_BIT = 2;
   localparam int unsigned MGBM_CTRL_FLOW_BIT = 3;
   localparam int unsigned MGBM_CTRL_DID_LSB = 8;
   localparam int unsigned MGBM_CTRL_RETRY_LSB = 16;
   // group info octet: slot count in [4:2], flow control in [5]
   localparam int unsigned MGBM_GI_SLOT_LSB = 2;
   localparam int unsigned MGBM_GI_FLOW_BIT = 5;
   // ==========================================================
   // reset values
   localparam logic [2:0] MGBM_SLOTS_RST = 3'h0;
   localparam logic [7:0] MGBM_DID_RST = 8'h00;
   localparam logic [4:0] MGBM_BUF_RST = 5'h1F;
   localparam logic [3:0] MGBM_RETRY_RST = 4'h3;
   localparam logic [7:0] MGBM_SEQ_RST = 8'h00;
   // ==========================================================
   // timing: confirmation timeout
   localparam int unsigned MGBM_CLK_HZ = 10_000_000;
   localparam int unsigned MGBM_TCNF_US = 100;
   localparam int unsigned MGBM_TCNF_CYC =
      (MGBM_TCNF_US * (MGBM_CLK_HZ / 1_000_000) > 0) ?
      MGBM_TCNF_US * (MGBM_CLK_HZ / 1_000_000) : 1;
   // ==========================================================
   // binding states
   typedef enum logic [3:0] {
      MGBM_IDLE = 4'b0001,
      MGBM_SEND = 4'b0010,
      MGBM_WAIT = 4'b0100,
      MGBM_DONE = 4'b1000
   } mgbm_state_e;
endpackage

//--- hw/mgbm_bat_mem.sv
// bit-allocation table id memory, one valid bit per table id
// assumes a single clock; read data come out of a register
`timescale 1ns/10ps
`default_nettype none
module mgbm_bat_mem (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic [4:0] wr_idx,
   input wire logic wr_val,
   input wire logic [4:0] rd_idx,
   output logic rd_val,
   output logic [31:0] all_val
);
   logic [31:0] mem_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_r <= 32'h0000_0000;
         rd_val <= 1'b0;
         all_val <= 32'h0000_0000;
      end else begin
         if (wr_en) begin
            mem_r[wr_idx] <= wr_val;
         end
         rd_val <= mem_r[rd_idx];
         all_val <= mem_r;
      end
   end
endmodule
`default_nettype wire

//--- hw/mgbm_top.sv
// multicast group binding maintenance, transmitter side, apb slave
// assumes a message engine that sends an update on upd_send and
// reports confirmations, removals and buffer sizes through registers
//
// Notes on behaviour
// R01: membership, slot or table change sends update; a table write in the send state is not sent
// R02: slot assignment effective when header count changes
// R03: old slot count held until all confirm
// R04: same slot count keeps existing slot assignment
// R05: receivers keep acking in held slot
// R06: removal request any time, receiver confirms
// R07: removed receiver sends ack field 111
// R08: split gives each group fresh did
// R09: every update runs full initialization again
// R10: changed table gets a new table id
// R11: update lists every active table id
// R12: new tables unused until all confirm
// R13: receivers drop tables missing from update
// R14: change while waiting restarts, higher sequence
// R15: termination releases did after all confirm
// R16: empty membership terminates group, frees did
// R17: minimum of reported buffer sizes readvertised
// R18: old table used until binding completes
// R19: timeout resends update until retries exhausted
// R20: zero receive nodes means did released
// R21: slot count in group octet bits 4:2
// R22: per-receiver pending confirmation record gates changes
`timescale 1ns/10ps
`default_nettype none
module mgbm_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic upd_send,
   output logic [7:0] upd_seq,
   output logic [7:0] upd_did,
   output logic [7:0] upd_grp_octet,
   output logic [7:0] upd_members,
   output logic [31:0] upd_bat_list,
   output logic [4:0] upd_min_buf,
   output logic [2:0] hdr_slots,
   output logic [31:0] tx_bat_list,
   output logic did_valid
);
   // ==========================================================
   // state
   typedef struct packed {
      mgbm_pkg::mgbm_state_e st;
      logic [7:0] memb;
      logic [2:0] slots_new;
      logic [2:0] slots_hdr;
      logic [7:0] pend;
      logic [7:0] seq;
      logic [7:0] did;
      logic did_valid;
      logic term;
      logic flow;
      logic [3:0] retry_max;
      logic [3:0] retry_cnt;
      logic [15:0] tmr;
      logic [4:0] min_buf;
      logic [4:0] min_acc;
      logic [31:0] tx_bats;
      logic [7:0] rmv_pend;
      logic fail;
      logic send;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } mgbm_state_s;

   mgbm_state_s s_r;
   mgbm_state_s s_nxt;
   logic bat_wr_en;
   logic [4:0] bat_wr_idx;
   logic bat_wr_val;
   logic bat_rd_val;
   logic [31:0] bat_active;

   function automatic logic [4:0] min5(input logic [4:0] a,
                                       input logic [4:0] b);
      min5 = (a < b) ? a : b;
   endfunction

   mgbm_bat_mem u_bat (
      .clk(clk),
      .arst_n(arst_n),
      .wr_en(bat_wr_en),
      .wr_idx(bat_wr_idx),
      .wr_val(bat_wr_val),
      .rd_idx(paddr[6:2]),
      .rd_val(bat_rd_val),
      .all_val(bat_active)
   );

   logic acc;
   logic wr;
   assign acc = psel && penable && !s_r.pready;
   assign wr = acc && pwrite;
   assign bat_wr_en = wr && (paddr == mgbm_pkg::MGBM_BATW_OFS); // R10
   assign bat_wr_idx = pwdata[4:0];
   assign bat_wr_val = pwdata[8];

   // ==========================================================
   // next state
   always_comb begin
      logic start;
      logic change;
      logic [7:0] cnf;
      start = 1'b0;
      change = 1'b0;
      cnf = 8'h00;
      s_nxt = s_r;
      s_nxt.send = 1'b0;
      s_nxt.pready = acc;
      s_nxt.pslverr = 1'b0;
      // register writes
      if (wr) begin
         case (paddr)
            mgbm_pkg::MGBM_CTRL_OFS: begin
               s_nxt.flow = pwdata[mgbm_pkg::MGBM_CTRL_FLOW_BIT];
               s_nxt.retry_max =
                  pwdata[mgbm_pkg::MGBM_CTRL_RETRY_LSB +: 4];
               if (pwdata[mgbm_pkg::MGBM_CTRL_SPLIT_BIT] &&
                   pwdata[mgbm_pkg::MGBM_CTRL_DID_LSB +: 8] != s_r.did)
               begin
                  s_nxt.did = pwdata[mgbm_pkg::MGBM_CTRL_DID_LSB +: 8]; // R08
                  s_nxt.did_valid = 1'b1;
                  change = 1'b1;
               end
               if (pwdata[mgbm_pkg::MGBM_CTRL_TERM_BIT]) begin
                  s_nxt.term = 1'b1; // R15
                  change = 1'b1;
               end
               if (pwdata[mgbm_pkg::MGBM_CTRL_SEND_BIT]) begin
                  change = 1'b1;
               end
            end
            mgbm_pkg::MGBM_MEMB_OFS: begin
               s_nxt.memb = pwdata[7:0];
               change = 1'b1; // R01
            end
            mgbm_pkg::MGBM_SLOT_OFS: begin
               s_nxt.slots_new = pwdata[2:0];
               change = 1'b1; // R01
            end
            mgbm_pkg::MGBM_BATW_OFS: change = 1'b1; // R01
            mgbm_pkg::MGBM_CNF_OFS: begin
               cnf = pwdata[7:0];
               if (!s_r.flow) begin
                  s_nxt.min_acc = min5(s_r.min_acc, pwdata[12:8]); // R17
               end
            end
            mgbm_pkg::MGBM_RMV_OFS: begin
               // removal confirmations drop members; slot stays held
               s_nxt.memb = s_r.memb & ~pwdata[7:0]; // R06
               s_nxt.rmv_pend = s_r.rmv_pend & ~pwdata[7:0];
               if (pwdata[15:8] != 8'h00) begin
                  s_nxt.rmv_pend = s_r.rmv_pend | pwdata[15:8]; // R07
               end
               if (pwdata[7:0] != 8'h00) begin
                  change = 1'b1;
               end
            end
            default: begin
               s_nxt.pslverr = !(paddr == mgbm_pkg::MGBM_STAT_OFS ||
                                 paddr == mgbm_pkg::MGBM_BATA_OFS ||
                                 paddr == mgbm_pkg::MGBM_BUF_OFS ||
                                 paddr == mgbm_pkg::MGBM_GRPI_OFS);
            end
         endcase
      end
      // register reads
      s_nxt.prdata = mgbm_pkg::MGBM_ZERO_WORD;
      if (acc && !pwrite) begin
         case (paddr)
            mgbm_pkg::MGBM_CTRL_OFS: s_nxt.prdata = {12'h000,
               s_r.retry_max, s_r.did, 4'h0, s_r.flow, 3'h0};
            mgbm_pkg::MGBM_STAT_OFS: s_nxt.prdata = {8'h00, s_r.seq,
               s_r.pend, s_r.retry_cnt, s_r.fail, s_r.did_valid,
               s_r.term, 1'b0} | {28'h000_0000, s_r.st};
            mgbm_pkg::MGBM_MEMB_OFS: s_nxt.prdata = {24'h00_0000, s_r.memb};
            mgbm_pkg::MGBM_SLOT_OFS: s_nxt.prdata = {24'h00_0000,
               2'b00, s_r.slots_hdr, s_r.slots_new};
            mgbm_pkg::MGBM_BATA_OFS: s_nxt.prdata = s_r.tx_bats;
            mgbm_pkg::MGBM_RMV_OFS: s_nxt.prdata = {16'h0000,
               s_r.rmv_pend, 8'h00};
            mgbm_pkg::MGBM_BUF_OFS: s_nxt.prdata = {27'h000_0000,
               s_r.min_buf};
            mgbm_pkg::MGBM_GRPI_OFS: s_nxt.prdata = {24'h00_0000,
               upd_grp_octet};
            mgbm_pkg::MGBM_BATW_OFS: s_nxt.prdata = {31'h0000_0000,
               bat_rd_val};
            mgbm_pkg::MGBM_CNF_OFS: s_nxt.prdata = mgbm_pkg::MGBM_ZERO_WORD;
            default: s_nxt.pslverr = 1'b1;
         endcase
      end
      // confirmations clear pending bits (record of outstanding)
      s_nxt.pend = s_r.pend & ~cnf; // R22
      // group emptied by removals terminates the group
      if (s_r.did_valid && s_r.memb == 8'h00 && !s_r.term &&
          s_r.st == mgbm_pkg::MGBM_IDLE && s_r.pend == 8'h00) begin
         s_nxt.term = 1'b1; // R16
         start = 1'b1;
      end
      if (change) begin
         start = 1'b1; // R14
      end
      case (s_r.st)
         mgbm_pkg::MGBM_IDLE: begin
            if (start) begin
               s_nxt.st = mgbm_pkg::MGBM_SEND;
            end
         end
         mgbm_pkg::MGBM_SEND: begin
            // full update each time, fresh pending set and timer
            s_nxt.send = 1'b1; // R09
            s_nxt.seq = s_r.seq + 8'h01; // R14
            // a write landing in this cycle is folded into this update, except a table write, which this update does not list
            s_nxt.pend = s_nxt.term ? (s_nxt.memb | s_nxt.rmv_pend)
                                    : s_nxt.memb;
            s_nxt.tmr = 16'(mgbm_pkg::MGBM_TCNF_CYC);
            s_nxt.min_acc = mgbm_pkg::MGBM_BUF_RST;
            s_nxt.st = mgbm_pkg::MGBM_WAIT;
         end
         mgbm_pkg::MGBM_WAIT: begin
            s_nxt.tmr = s_r.tmr - 16'h0001;
            if (start) begin
               s_nxt.retry_cnt = 4'h0; // R14
               s_nxt.st = mgbm_pkg::MGBM_SEND;
            end else if (s_nxt.pend == 8'h00) begin
               s_nxt.st = mgbm_pkg::MGBM_DONE;
            end else if (s_r.tmr == 16'h0000) begin
               if (s_r.retry_cnt < s_r.retry_max) begin
                  s_nxt.retry_cnt = s_r.retry_cnt + 4'h1; // R19
                  s_nxt.st = mgbm_pkg::MGBM_SEND;
               end else begin
                  s_nxt.fail = 1'b1; // R19
                  s_nxt.st = mgbm_pkg::MGBM_IDLE;
               end
            end
         end
         mgbm_pkg::MGBM_DONE: begin
            // all confirmed: header count and tables now move; did freed if terminating
            s_nxt.slots_hdr = s_r.slots_new; // R03 R02 R04
            s_nxt.tx_bats = bat_active; // R12 R18
            s_nxt.rmv_pend = 8'h00;
            s_nxt.retry_cnt = 4'h0;
            s_nxt.fail = 1'b0;
            if (!s_r.flow) begin
               s_nxt.min_buf = s_r.min_acc; // R17
            end
            if (s_r.term) begin
               s_nxt.did_valid = 1'b0; // R15 R16
               s_nxt.term = 1'b0;
               s_nxt.memb = 8'h00;
               s_nxt.slots_hdr = mgbm_pkg::MGBM_SLOTS_RST;
            end
            s_nxt.st = (start || (!s_r.flow && s_r.min_acc != s_r.min_buf
                        && !s_r.term)) ? mgbm_pkg::MGBM_SEND
                        : mgbm_pkg::MGBM_IDLE; // R17
         end
         default: s_nxt.st = mgbm_pkg::MGBM_IDLE;
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{st: mgbm_pkg::MGBM_IDLE, memb: 8'h00,
                  slots_new: mgbm_pkg::MGBM_SLOTS_RST,
                  slots_hdr: mgbm_pkg::MGBM_SLOTS_RST, pend: 8'h00,
                  seq: mgbm_pkg::MGBM_SEQ_RST, did: mgbm_pkg::MGBM_DID_RST,
                  did_valid: 1'b0, term: 1'b0, flow: 1'b0,
                  retry_max: mgbm_pkg::MGBM_RETRY_RST, retry_cnt: 4'h0,
                  tmr: 16'h0000, min_buf: mgbm_pkg::MGBM_BUF_RST,
                  min_acc: mgbm_pkg::MGBM_BUF_RST, tx_bats: 32'h0000_0000,
                  rmv_pend: 8'h00, fail: 1'b0, send: 1'b0,
                  prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign upd_send = s_r.send;
   assign upd_seq = s_r.seq;
   assign upd_did = s_r.did;
   // slot count at [4:2], flow at [5], reserved zero
   assign upd_grp_octet = {2'b00, s_r.flow, s_r.slots_new, 2'b00}; // R21
   // zero members on termination marks the did as released
   assign upd_members = s_r.term ? 8'h00 : s_r.memb; // R20
   assign upd_bat_list = bat_active; // R11
   assign upd_min_buf = s_r.min_buf;
   assign hdr_slots = s_r.slots_hdr;
   assign tx_bat_list = s_r.tx_bats;
   assign did_valid = s_r.did_valid;

   // ==========================================================
   // checks
   a_hdr_hold: assert property (@(posedge clk) disable iff (!arst_n) // R03
      (s_r.pend != 8'h00) |=> $stable(hdr_slots))
      else $error("slot count changed with confirmations pending");
   a_bat_hold: assert property (@(posedge clk) disable iff (!arst_n) // R12
      (s_r.st == mgbm_pkg::MGBM_WAIT) |=> $stable(tx_bat_list))
      else $error("tables changed before all confirmed");
   a_send_seq: assert property (@(posedge clk) disable iff (!arst_n) // R14
      upd_send |-> upd_seq == $past(upd_seq) + 8'h01)
      else $error("update without higher sequence");
   a_did_free: assert property (@(posedge clk) disable iff (!arst_n) // R15
      $fell(did_valid) |-> $past(s_r.pend) == 8'h00)
      else $error("did freed with confirmations pending");
   a_wait_send: assert property (@(posedge clk) disable iff (!arst_n) // R09
      (s_r.st == mgbm_pkg::MGBM_SEND) |=> upd_send)
      else $error("send state without update pulse");
   a_pend_load: assert property (@(posedge clk) disable iff (!arst_n) // R22
      upd_send && !s_r.term |-> s_r.pend == s_r.memb)
      else $error("pending record not loaded on update");
   a_slot_field: assert property (@(posedge clk) disable iff (!arst_n) // R21
      upd_grp_octet[4:2] == s_r.slots_new && upd_grp_octet[7:6] == 2'b00)
      else $error("slot field misplaced");
   a_rel_zero: assert property (@(posedge clk) disable iff (!arst_n) // R20
      upd_send && s_r.term |-> upd_members == 8'h00)
      else $error("release update lists members");
   a_apb_ready: assert property (@(posedge clk) disable iff (!arst_n) // apb access answered one cycle after penable
      psel && penable && !pready |=> pready)
      else $error("apb access not answered in one cycle");
endmodule
`default_nettype wire

//--- verif/mgbm_rx_group.sv
// behavioural model of the receivers that sit behind the message engine
// assumes the bench turns each due confirmation into a write of the
// confirm register and then pulses cnf_take
`timescale 1ns/10ps
`default_nettype none
module mgbm_rx_group (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic upd_send,
   input wire logic [7:0] upd_members,
   input wire logic slow,
   input wire logic mute,
   input wire logic cnf_take,
   output logic cnf_due,
   output logic [7:0] cnf_mask
);
   logic [7:0] last_members;
   int cnt;
   // =====================================================
   // every listed receiver answers each update unless mute is set
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnf_due <= 1'b0;
         cnf_mask <= 8'h00;
         last_members <= 8'h00;
         cnt <= 0;
      end else if (upd_send === 1'b1) begin
         // a release update lists nobody: the old members answer it
         cnf_mask <= (upd_members == 8'h00) ? last_members : upd_members;
         last_members <= upd_members;
         cnf_due <= 1'b0;
         cnt <= mute ? 0 : (slow ? 40 : 2);
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         cnt <= 0;
         cnf_due <= 1'b1;
      end else if (cnf_take) begin
         cnf_due <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- verif/multicast_group_binding_maint_bench.sv
// self-checking bench for the binding maintenance block
// assumes the apb map of the package and a one-wait-state answer
`timescale 1ns/10ps
`default_nettype none
module multicast_group_binding_maint_bench;
   typedef struct {
      logic [7:0] seq;
      logic [7:0] mem;
      logic [2:0] slt;
      logic [31:0] bat;
      logic [4:0] buff;
   } mgbm_note_s;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, upd_bat_list, tx_bat_list, rd;
   logic pready, pslverr, upd_send, did_valid, err;
   logic [7:0] upd_seq, upd_did, upd_grp_octet, upd_members;
   logic [4:0] upd_min_buf, ebuf, bv;
   logic [2:0] hdr_slots, eslt;
   logic [7:0] eseq, emem;
   logic [31:0] ebat;
   logic slow = 1'b0, mute = 1'b0, cnf_take = 1'b0, cnf_due;
   logic [7:0] cnf_mask;
   int failures = 0, checks = 0, seed = 32'hdefb;
   mgbm_note_s exp_q[$];
   always #50 clk = ~clk;
   mgbm_top i_dut (.clk(clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .upd_send(upd_send), .upd_seq(upd_seq), .upd_did(upd_did),
      .upd_grp_octet(upd_grp_octet), .upd_members(upd_members),
      .upd_bat_list(upd_bat_list), .upd_min_buf(upd_min_buf),
      .hdr_slots(hdr_slots), .tx_bat_list(tx_bat_list),
      .did_valid(did_valid));
   mgbm_rx_group i_rx (.clk(clk), .arst_n(arst_n), .upd_send(upd_send),
      .upd_members(upd_members), .slow(slow), .mute(mute),
      .cnf_take(cnf_take), .cnf_due(cnf_due), .cnf_mask(cnf_mask));
   // =====================================================
   // shared helpers
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic note();
      eseq = eseq + 8'h01;
      exp_q.push_back('{eseq, emem, eslt, ebat, ebuf});
   endtask
   task automatic drain(input int lim);
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < lim) begin
         n++;
         @(posedge clk);
      end
      chk("update count", 32'h0, 32'(exp_q.size()));
   endtask
   task automatic confirm(input logic [7:0] m, input logic [4:0] b);
      int n;
      n = 0;
      while (cnf_due !== 1'b1 && n < 100) begin
         n++;
         @(posedge clk);
      end
      apb(1'b1, mgbm_pkg::MGBM_CNF_OFS, {19'h0, b, m & cnf_mask});
      cnf_take <= 1'b1;
      @(posedge clk);
      cnf_take <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("counts: checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // =====================================================
   // monitor: every update pulse takes the oldest note
   always @(posedge clk) begin
      mgbm_note_s n;
      if (upd_send === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unexpected update", 32'h0, 32'h1);
         end else begin
            n = exp_q.pop_front();
            chk("upd_seq", 32'(n.seq), 32'(upd_seq));
            chk("upd_members", 32'(n.mem), 32'(upd_members));
            chk("slot field", 32'(n.slt), 32'(upd_grp_octet[4:2]));
            chk("upd_bat_list", n.bat, upd_bat_list);
            chk("upd_min_buf", 32'(n.buff), 32'(upd_min_buf));
         end
      end
   end
   initial begin
      #(60000 * 100);
      failures++;
      report_and_stop();
   end
   // =====================================================
   // main sequence
   initial begin
      eseq = mgbm_pkg::MGBM_SEQ_RST;
      emem = 8'h00;
      eslt = 3'h0;
      ebat = 32'h0000_0000;
      ebuf = mgbm_pkg::MGBM_BUF_RST;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk("hdr_slots rst", 32'h0, 32'(hdr_slots));
      chk("min_buf rst", 32'h1F, 32'(upd_min_buf));
      chk("did_valid rst", 32'h0, 32'(did_valid));
      // membership and slot change, confirmations in two halves
      emem = 8'h0F;
      note();
      apb(1'b1, mgbm_pkg::MGBM_MEMB_OFS, 32'h0000_000F);
      drain(50);
      confirm(8'h0F, 5'h1F);
      eslt = 3'h3;
      note();
      slow <= 1'b1;
      apb(1'b1, mgbm_pkg::MGBM_SLOT_OFS, 32'h0000_0003);
      drain(50);
      confirm(8'h03, 5'h1F);
      repeat (5) @(posedge clk);
      chk("hdr_slots held", 32'h0, 32'(hdr_slots));
      apb(1'b1, mgbm_pkg::MGBM_CNF_OFS, 32'h0000_1F0C);
      repeat (5) @(posedge clk);
      chk("hdr_slots new", 32'h3, 32'(hdr_slots));
      $display("test slots done");
      // new table id held back until all confirm
      ebat = 32'h0000_0020;
      note();
      slow <= 1'b0;
      apb(1'b1, mgbm_pkg::MGBM_BATW_OFS, 32'h0000_0105);
      drain(50);
      chk("tx table early", 32'h0, 32'(tx_bat_list[5]));
      confirm(8'h0F, 5'h1F);
      repeat (5) @(posedge clk);
      chk("tx table live", 32'h1, 32'(tx_bat_list[5]));
      $display("test tables done");
      // change while confirmations are outstanding restarts
      emem = 8'h07;
      note();
      slow <= 1'b1;
      apb(1'b1, mgbm_pkg::MGBM_MEMB_OFS, 32'h0000_0007);
      drain(50);
      emem = 8'h03;
      note();
      apb(1'b1, mgbm_pkg::MGBM_MEMB_OFS, 32'h0000_0003);
      drain(50);
      confirm(8'h03, 5'h1F);
      $display("test restart done");
      // silent receivers: the update is sent again after the timeout
      mute <= 1'b1;
      eslt = 3'h2;
      note();
      note();
      apb(1'b1, mgbm_pkg::MGBM_SLOT_OFS, 32'h0000_0002);
      drain(1200);
      mute <= 1'b0;
      apb(1'b1, mgbm_pkg::MGBM_CNF_OFS, 32'h0000_1F03);
      $display("test timeout done");
      // split to a fresh did; reported buffers: smallest advertised again
      ebuf = 5'h1F;
      note();
      apb(1'b1, mgbm_pkg::MGBM_CTRL_OFS, 32'h0003_0105);
      drain(50);
      chk("did_valid split", 32'h1, 32'(did_valid));
      chk("upd_did", 32'h0000_0001, 32'(upd_did));
      for (int i = 0; i < 2; i++) begin
         bv = 5'(($unsigned($random(seed)) % 30) + 1);
         if (bv < ebuf) ebuf = bv;
         if (i == 1) note();
         apb(1'b1, mgbm_pkg::MGBM_CNF_OFS, {19'h0, bv, 8'(1 << i)});
      end
      drain(50);
      confirm(8'h03, ebuf);
      $display("test buffer done");
      // unmapped place is refused
      apb(1'b0, 8'h3C, 32'h0000_0000);
      chk("unmapped err", 32'h1, 32'(err));
      chk("unmapped data", 32'h0, rd);
      // removal: the leaving member drops out of the next update
      emem = 8'h01;
      note();
      apb(1'b1, mgbm_pkg::MGBM_RMV_OFS, 32'h0000_0200);
      apb(1'b0, mgbm_pkg::MGBM_RMV_OFS, 32'h0000_0000);
      chk("removal pending", 32'h0000_0200, rd);
      apb(1'b1, mgbm_pkg::MGBM_RMV_OFS, 32'h0000_0002);
      drain(50);
      confirm(8'h01, ebuf);
      $display("test removal done");
      // termination releases the group once all confirm
      emem = 8'h00;
      note();
      apb(1'b1, mgbm_pkg::MGBM_CTRL_OFS, 32'h0000_0002);
      drain(50);
      confirm(8'h03, ebuf);
      repeat (5) @(posedge clk);
      chk("did released", 32'h0, 32'(did_valid));
      $display("test terminate done");
      report_and_stop();
   end
endmodule
`default_nettype wire
